// *** hdl/plcb_defines.vh ***
`ifndef PLCB_DEFINES_VH
`define PLCB_DEFINES_VH

// Register byte addresses on the host serial control bus
`define PLCB_ADDR_CURR 8'h32
`define PLCB_ADDR_VOLT 8'h33
`define PLCB_ADDR_CONN 8'h34

// Reset values
`define PLCB_RST_CURR 8'hBF
`define PLCB_RST_VOLT 8'hA5
`define PLCB_RST_CONN 8'h3F

// Field positions
`define PLCB_MINCUR_BIT 7
`define PLCB_FORCE_BIT 6
`define PLCB_CURR_HI 5
`define PLCB_CURR_LO 0
`define PLCB_DISCH_BIT 7
`define PLCB_DROP_HI 6
`define PLCB_DROP_LO 4
`define PLCB_HLD_HI 3
`define PLCB_HLD_LO 2
`define PLCB_HREF_HI 1
`define PLCB_HREF_LO 0
`define PLCB_MON_BIT 7
`define PLCB_CONSEL_BIT 6
`define PLCB_REQRTY_HI 5
`define PLCB_REQRTY_LO 3
`define PLCB_PKTRTY_HI 2
`define PLCB_PKTRTY_LO 0

// Analog scale figures, in microamps and tenths of millivolts
`define PLCB_CURR_LSB_UA 3125
`define PLCB_CURR_FS_UA 200000
`define PLCB_DROP_BASE_DMV 500
`define PLCB_DROP_STEP_DMV 250
`define PLCB_HREF_BASE_DMV 1125
`define PLCB_HLD_BASE_DMV 500
`define PLCB_OFS_STEP_DMV 125

`endif

// *** hdl/plcb_retry_cnt.v ***
`timescale 1ns/100ps
// Counts master NACKs for one transfer item and flags when the limit is met
module plcb_retry_cnt #(
    parameter W = 8
) (
    input wire ref_clk_i,
    input wire reset_i,
    input wire start_i,
    input wire ack_i,
    input wire nack_i,
    input wire [W-1:0] limit_i,
    output reg retry_o,
    output reg error_o
);
    reg [W-1:0] cnt_r;
    wire [W-1:0] cnt_inc;
    assign cnt_inc = cnt_r + {{(W-1){1'b0}}, 1'b1};

    always @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            cnt_r <= {W{1'b0}};
            retry_o <= 1'b0;
            error_o <= 1'b0;
        end
        else
        begin
            retry_o <= 1'b0;
            error_o <= 1'b0;
            if (start_i || ack_i)
                cnt_r <= {W{1'b0}};
            else if (nack_i)
            begin
                // Clear the count on reaching the limit so a misbehaving master cannot wrap it
                if (cnt_inc >= limit_i)
                begin
                    error_o <= 1'b1;
                    cnt_r <= {W{1'b0}};
                end
                else
                begin
                    retry_o <= 1'b1;
                    cnt_r <= cnt_inc;
                end
            end
        end
    end
endmodule

// *** hdl/plcb_config_bank.v ***
`timescale 1ns/100ps
`include "plcb_defines.vh"
module plcb_config_bank (
    input wire ref_clk_i,
    input wire reset_i,
    input wire wr_en_i,
    input wire rd_en_i,
    input wire [7:0] addr_i,
    input wire [7:0] wdata_i,
    input wire fifo_clr_wr_i,
    input wire rx_data_in_i,
    input wire charger_lower_i,
    input wire [5:0] charger_limit_i,
    input wire line_below_sys_i,
    input wire line_below_bat_i,
    input wire system_undervoltage_i,
    input wire detect_fsm_en_i,
    input wire line_supply_i,
    input wire presence_poll_i,
    input wire bulk_mode_i,
    input wire req_start_i,
    input wire req_ack_i,
    input wire req_nack_i,
    input wire pkt_start_i,
    input wire pkt_ack_i,
    input wire pkt_nack_i,
    input wire dout_req_i,
    output reg [7:0] rdata_o,
    output reg rvalid_o,
    output reg [5:0] line_input_current_limit_o,
    output reg discharge_en_o,
    output reg [2:0] dropout_sel_o,
    output reg [1:0] upper_limit_offset_sel_o,
    output reg [1:0] lower_limit_offset_sel_o,
    output reg monitor_line_o,
    output reg connected_o,
    output reg req_resend_o,
    output reg req_error_o,
    output reg pkt_retry_o,
    output reg pkt_error_o,
    output reg dout_req_nack_o,
    output reg rx_buffer_full_flag_o
);
    reg [7:0] link_current_limit_cfg_r;
    reg [7:0] link_voltage_threshold_cfg_r;
    reg [7:0] link_connect_retry_cfg_r;
    reg rx_full_r;
    reg [7:0] rdata_nxt;
    reg [5:0] limit_nxt;
    wire force_lim = link_current_limit_cfg_r[`PLCB_FORCE_BIT];
    wire min_cur = link_current_limit_cfg_r[`PLCB_MINCUR_BIT];
    wire [5:0] curr_field = link_current_limit_cfg_r[`PLCB_CURR_HI:`PLCB_CURR_LO];
    wire [2:0] req_code = link_connect_retry_cfg_r[`PLCB_REQRTY_HI:`PLCB_REQRTY_LO];
    wire [2:0] pkt_code = link_connect_retry_cfg_r[`PLCB_PKTRTY_HI:`PLCB_PKTRTY_LO];
    wire [8:0] req_limit = 9'h001 << req_code;
    wire [3:0] pkt_limit = {1'b0, pkt_code} + 4'h1;
    wire req_resend_w;
    wire req_error_w;
    wire pkt_retry_w;
    wire pkt_error_w;

    function hit;
        input [7:0] a;
        input [7:0] b;
        begin
            hit = (a == b);
        end
    endfunction

    // Register writes
    always @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            link_current_limit_cfg_r <= `PLCB_RST_CURR;
            link_voltage_threshold_cfg_r <= `PLCB_RST_VOLT;
            link_connect_retry_cfg_r <= `PLCB_RST_CONN;
        end
        else if (wr_en_i)
        begin
            if (hit(addr_i, `PLCB_ADDR_CURR))
                link_current_limit_cfg_r <= wdata_i;
            if (hit(addr_i, `PLCB_ADDR_VOLT))
                link_voltage_threshold_cfg_r <= wdata_i;
            if (hit(addr_i, `PLCB_ADDR_CONN))
                link_connect_retry_cfg_r <= wdata_i;
        end
    end

    // Readback; unmapped addresses return zero
    always @*
    begin
        rdata_nxt = 8'h00;
        if (hit(addr_i, `PLCB_ADDR_CURR))
            rdata_nxt = link_current_limit_cfg_r;
        else if (hit(addr_i, `PLCB_ADDR_VOLT))
            rdata_nxt = link_voltage_threshold_cfg_r;
        else if (hit(addr_i, `PLCB_ADDR_CONN))
            rdata_nxt = link_connect_retry_cfg_r;
    end

    // Effective current limit code; 3.125 mA per code
    always @*
    begin
        limit_nxt = curr_field;
        if (!force_lim)
        begin
            // Internal control may only lower, never raise, the programmed cap
            if (charger_lower_i && (charger_limit_i < curr_field))
                limit_nxt = charger_limit_i;
            if (min_cur && (line_below_sys_i || line_below_bat_i))
                limit_nxt = 6'h00;
        end
    end

    plcb_retry_cnt #(.W(9)) u_req_cnt (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .start_i(req_start_i),
        .ack_i(req_ack_i),
        .nack_i(req_nack_i && bulk_mode_i),
        .limit_i(req_limit),
        .retry_o(req_resend_w),
        .error_o(req_error_w)
    );

    plcb_retry_cnt #(.W(4)) u_pkt_cnt (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .start_i(pkt_start_i),
        .ack_i(pkt_ack_i),
        .nack_i(pkt_nack_i && bulk_mode_i),
        .limit_i(pkt_limit),
        .retry_o(pkt_retry_w),
        .error_o(pkt_error_w)
    );

    // Read data and analog control selectors
    always @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            rdata_o <= 8'h00;
            rvalid_o <= 1'b0;
            line_input_current_limit_o <= 6'h00;
            discharge_en_o <= 1'b0;
            dropout_sel_o <= 3'h0;
            upper_limit_offset_sel_o <= 2'h0;
            lower_limit_offset_sel_o <= 2'h0;
        end
        else
        begin
            rdata_o <= rd_en_i ? rdata_nxt : rdata_o;
            rvalid_o <= rd_en_i;
            line_input_current_limit_o <= limit_nxt;
            discharge_en_o <= link_voltage_threshold_cfg_r[`PLCB_DISCH_BIT] && system_undervoltage_i;
            dropout_sel_o <= link_voltage_threshold_cfg_r[`PLCB_DROP_HI:`PLCB_DROP_LO];
            upper_limit_offset_sel_o <= link_voltage_threshold_cfg_r[`PLCB_HREF_HI:`PLCB_HREF_LO];
            lower_limit_offset_sel_o <= link_voltage_threshold_cfg_r[`PLCB_HLD_HI:`PLCB_HLD_LO];
        end
    end

    // Line monitoring and connection state
    always @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            monitor_line_o <= 1'b0;
            connected_o <= 1'b0;
        end
        else
        begin
            monitor_line_o <= !detect_fsm_en_i && line_supply_i
                && !link_connect_retry_cfg_r[`PLCB_MON_BIT];
            // Connection drops whenever line power goes away
            if (!line_supply_i)
                connected_o <= 1'b0;
            else if (link_connect_retry_cfg_r[`PLCB_CONSEL_BIT] || presence_poll_i)
                connected_o <= 1'b1;
        end
    end

    // Retry answers, re-timed so every top-level output leaves a flip-flop here
    always @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            req_resend_o <= 1'b0;
            req_error_o <= 1'b0;
            pkt_retry_o <= 1'b0;
            pkt_error_o <= 1'b0;
        end
        else
        begin
            req_resend_o <= req_resend_w;
            req_error_o <= req_error_w;
            pkt_retry_o <= pkt_retry_w;
            pkt_error_o <= pkt_error_w;
        end
    end

    // Receive buffer full flag and refusal of data-output requests
    always @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            dout_req_nack_o <= 1'b0;
            rx_full_r <= 1'b0;
            rx_buffer_full_flag_o <= 1'b0;
        end
        else
        begin
            dout_req_nack_o <= dout_req_i && rx_full_r;
            // New data wins over a clear in the same cycle
            if (rx_data_in_i)
                rx_full_r <= 1'b1;
            else if (fifo_clr_wr_i)
                rx_full_r <= 1'b0;
            rx_buffer_full_flag_o <= rx_data_in_i || (rx_full_r && !fifo_clr_wr_i);
        end
    end
endmodule

// *** verification/plcb_cfg_checker.sv ***
`timescale 1ns/100ps
module plcb_cfg_checker (
    input wire ref_clk_i, reset_i, wr_en_i, bulk_mode_i, pkt_nack_i, req_nack_i, dout_req_i,
    input wire fifo_clr_wr_i, system_undervoltage_i, line_supply_i, discharge_en_o, connected_o,
    input wire dout_req_nack_o, rx_buffer_full_flag_o, pkt_retry_o, pkt_error_o, req_resend_o, req_error_o,
    input wire [7:0] addr_i, wdata_i,
    input wire [5:0] line_input_current_limit_o,
    input wire [2:0] dropout_sel_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (reset_i);
    // A quiet cycle after the write, so the outputs two edges on belong to it
    sequence s_wr(a, b);
        wr_en_i && addr_i == a && b ##1 !(wr_en_i && addr_i == a);
    endsequence
    AST_FORCE_LIMIT: assert property (s_wr(8'h32, wdata_i[6]) |=>
        line_input_current_limit_o == $past(wdata_i[5:0], 2)) else $error("limit differs from field");
    AST_DROP_SEL: assert property (s_wr(8'h33, 1'b1) |=>
        dropout_sel_o == $past(wdata_i[6:4], 2)) else $error("dropout code differs");
    AST_DISCH: assert property (discharge_en_o |-> $past(system_undervoltage_i))
        else $error("discharge without undervoltage");
    AST_PKT_PAIR: assert property (pkt_nack_i && bulk_mode_i |-> ##2 pkt_retry_o ^ pkt_error_o)
        else $error("packet nack unanswered");
    AST_PKT_CAUSE: assert property (pkt_retry_o || pkt_error_o |-> $past(pkt_nack_i, 2))
        else $error("packet answer without nack");
    AST_REQ_OFF: assert property (req_nack_i && !bulk_mode_i |-> ##2 !(req_resend_o || req_error_o))
        else $error("request retry outside bulk");
    AST_DOUT_NACK: assert property (dout_req_i && rx_buffer_full_flag_o |=> dout_req_nack_o)
        else $error("request not refused");
    AST_FLAG_HOLD: assert property (rx_buffer_full_flag_o && !fifo_clr_wr_i |=> rx_buffer_full_flag_o)
        else $error("full flag dropped");
    AST_CONN: assert property (connected_o |-> $past(line_supply_i))
        else $error("connected without supply");
endmodule
bind plcb_config_bank plcb_cfg_checker chk (.*);

// *** verification/plcb_master_model.sv ***
`timescale 1ns/100ps
module plcb_master_model (
    input wire ref_clk_i, go_i, pkt_i,
    input wire [7:0] n_i,
    output reg req_nack_o = 1'b0, pkt_nack_o = 1'b0,
    output wire busy_o
);
    reg [7:0] left_r = 8'h0;
    reg [1:0] gap_r = 2'h0;
    // Spaced four cycles apart so each answer lands before the next refusal
    wire fire = left_r != 8'h0 && gap_r == 2'h3 && !go_i;
    assign busy_o = left_r != 8'h0;
    always @(posedge ref_clk_i)
    begin
        gap_r <= go_i ? 2'h0 : gap_r + 2'h1;
        left_r <= go_i ? n_i : left_r - {7'h0, fire};
        req_nack_o <= fire && !pkt_i;
        pkt_nack_o <= fire && pkt_i;
    end
endmodule

// *** verification/testbench.sv ***
`timescale 1ns/100ps
module testbench;
    logic ref_clk_i = 0, reset_i = 1, wr_en_i = 0, rd_en_i = 0, fifo_clr_wr_i = 0, rx_data_in_i = 0;
    logic charger_lower_i = 0, line_below_sys_i = 0, system_undervoltage_i = 0, detect_fsm_en_i = 0;
    logic line_supply_i = 0, bulk_mode_i = 1, req_start_i = 0, pkt_start_i = 0, dout_req_i = 0, go = 0, sel = 0;
    logic line_below_bat_i = 0, presence_poll_i = 0, req_ack_i = 0, pkt_ack_i = 0, ack_sel = 0;
    logic [7:0] addr_i = 0, wdata_i = 0, n_nack = 0;
    logic [5:0] charger_limit_i = 0;
    wire [7:0] rdata_o;
    wire [5:0] line_input_current_limit_o;
    wire [2:0] dropout_sel_o;
    wire [1:0] upper_limit_offset_sel_o, lower_limit_offset_sel_o;
    wire rvalid_o, discharge_en_o, monitor_line_o, connected_o, req_resend_o, req_error_o, pkt_retry_o;
    wire pkt_error_o, dout_req_nack_o, rx_buffer_full_flag_o, req_nack_i, pkt_nack_i, busy;
    int failures = 0, total_checks = 0, cycles = 0, n_retry = 0, n_err = 0;
    plcb_config_bank dut (.*);
    plcb_master_model master (.ref_clk_i(ref_clk_i), .go_i(go), .pkt_i(sel), .n_i(n_nack),
        .req_nack_o(req_nack_i), .pkt_nack_o(pkt_nack_i), .busy_o(busy));
    initial
    begin
        forever #4 ref_clk_i = ~ref_clk_i;
    end
    // Outputs are counted at the falling edge, where they have settled
    always @(negedge ref_clk_i)
    begin
        n_retry += pkt_retry_o | req_resend_o;
        n_err += pkt_error_o | req_error_o;
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            close_out;
        end
    end
    task close_out;
        $display("Checks %0d, failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task chk(input logic [7:0] got, exp);
        total_checks++;
        if (got !== exp)
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        failures += (got !== exp);
    endtask
    task tick(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask
    task wr(input logic [7:0] a, d);
        tick(1);
        {wr_en_i, addr_i, wdata_i} = {1'b1, a, d};
        tick(1);
        wr_en_i = 0;
        tick(2);
    endtask
    task rd(input logic [7:0] a, exp);
        tick(1);
        {rd_en_i, addr_i} = {1'b1, a};
        tick(1);
        rd_en_i = 0;
        chk({7'h0, rvalid_o}, 8'h01);
        chk(rdata_o, exp);
    endtask
    task run(input logic p, input logic [7:0] cfg, n, r, e);
        wr(8'h34, cfg);
        {n_retry, n_err, sel, go, n_nack, req_start_i} = {64'h0, p, 1'b1, n, !p};
        {pkt_start_i, pkt_ack_i} = {p && !ack_sel, p && ack_sel};
        tick(1);
        {go, pkt_start_i, pkt_ack_i, req_start_i} = 4'h0;
        for (int i = 0; i < 600 && busy; i++)
            tick(1);
        tick(4);
        chk(n_retry, r);
        chk(n_err, e);
    endtask
    task t_regs;
        rd(8'h32, 8'hBF);
        rd(8'h33, 8'hA5);
        rd(8'h34, 8'h3F);
        wr(8'h40, 8'hFF);
        rd(8'h40, 8'h00);
        chk(line_input_current_limit_o, 8'h3F);
    endtask
    task t_limit;
        {charger_lower_i, charger_limit_i} = {1'b1, 6'h03};
        wr(8'h32, 8'h55);
        chk(line_input_current_limit_o, 8'h15);
        wr(8'h32, 8'h15);
        chk(line_input_current_limit_o <= 6'h15, 8'h01);
        {charger_lower_i, line_below_sys_i} = 2'b01;
        wr(8'h32, 8'h95);
        chk(line_input_current_limit_o < 6'h15, 8'h01);
        {line_below_sys_i, line_below_bat_i} = 2'b01;
        tick(3);
        chk(line_input_current_limit_o < 6'h15, 8'h01);
        line_below_bat_i = 0;
        tick(3);
        chk(line_input_current_limit_o, 8'h15);
    endtask
    task t_volt;
        for (int c = 0; c < 8; c++)
        begin
            system_undervoltage_i = c[0];
            wr(8'h33, {1'b1, c[2:0], c[0], c[1], c[1:0]});
            chk(dropout_sel_o, c[2:0]);
            chk(upper_limit_offset_sel_o, c[1:0]);
            chk(lower_limit_offset_sel_o, {c[0], c[1]});
            chk(discharge_en_o, c[0]);
        end
    endtask
    task t_conn;
        line_supply_i = 1;
        wr(8'h34, 8'h3F);
        chk(monitor_line_o, 8'h01);
        chk(connected_o, 8'h00);
        wr(8'h34, 8'hFF);
        chk(monitor_line_o, 8'h00);
        chk(connected_o, 8'h01);
        line_supply_i = 0;
        tick(3);
        chk(connected_o, 8'h00);
        wr(8'h34, 8'h3F);
        line_supply_i = 1;
        tick(3);
        chk(connected_o, 8'h00);
        presence_poll_i = 1;
        tick(1);
        presence_poll_i = 0;
        tick(1);
        chk(connected_o, 8'h01);
        detect_fsm_en_i = 1;
        tick(2);
        chk(monitor_line_o, 8'h00);
        {detect_fsm_en_i, line_supply_i} = 2'b00;
        tick(2);
    endtask
    task t_dout;
        rx_data_in_i = 1;
        tick(1);
        rx_data_in_i = 0;
        tick(2);
        chk(rx_buffer_full_flag_o, 8'h01);
        dout_req_i = 1;
        tick(1);
        dout_req_i = 0;
        chk(dout_req_nack_o, 8'h01);
        fifo_clr_wr_i = 1;
        tick(1);
        {fifo_clr_wr_i, dout_req_i} = 2'b01;
        tick(1);
        dout_req_i = 0;
        chk(rx_buffer_full_flag_o, 8'h00);
        chk(dout_req_nack_o, 8'h00);
    endtask
    initial
    begin
        tick(10);
        reset_i = 0;
        t_regs;
        t_limit;
        t_volt;
        t_conn;
        for (int c = 0; c < 8; c++)
        begin
            run(1, {5'h0, c[2:0]}, c + 1, c, 1);
            run(0, {2'h0, c[2:0], 3'h0}, 1 << c, (1 << c) - 1, 1);
        end
        repeat (2) run(1, 8'h02, 2, 2, 0);
        ack_sel = 1;
        repeat (2) run(1, 8'h02, 2, 2, 0);
        ack_sel = 0;
        bulk_mode_i = 0;
        run(1, 8'h00, 1, 0, 0);
        t_dout;
        close_out;
    end
endmodule
